// ===== rtl/ecg_out_map.svh
/*
 * Register offsets, field positions, reset values and counts for the
 * front-end output control block.
 * Assumes byte-wide registers on an 8-bit address port.
 */
`ifndef ECG_OUT_MAP_SVH
`define ECG_OUT_MAP_SVH

// Register offsets
`define OFS_FILTER_BYPASS   8'h26
`define OFS_READY_SRC       8'h27
`define OFS_SYNC_CTRL       8'h28
`define OFS_READY_MASKING   8'h29
`define OFS_ALARM_MASK      8'h2a
`define OFS_ALARM_DEBOUNCE  8'h2e
`define OFS_LOOP_CFG        8'h2f
`define OFS_DATA_FIRST      8'h30
`define OFS_DATA_LAST       8'h3f
`define OFS_LOOP_PORT       8'h50

// Reset values
`define RST_FILTER_BYPASS   3'h0
`define RST_READY_SRC       6'h00
`define RST_SYNC_OFF        1'b1
`define RST_SYNC_SRC        6'h00
`define RST_READY_MASKING   2'h0
`define RST_ALARM_MASK      8'h00
`define RST_DEBOUNCE        4'h3
`define RST_LOOP_CFG        7'h00

// Field positions
`define SYNC_OFF_BIT        6
`define STARTUP_MASK_BIT    1
`define RESYNC_MASK_BIT     0
`define DETACH_MASK_BIT     3

// Masking interval lengths in output data periods
`define MASK_PERIODS_ECG    4'd6
`define MASK_PERIODS_PACE1  4'd6
`define MASK_PERIODS_PACE2  4'd11

// Alarm sampling divider, system clocks per alarm sample
`define SAMPLE_DIV_DEFAULT  16

`endif

// ===== rtl/ecg_out_pkg.sv
/*
 * Types for the front-end output control block.
 * Assumes the constants header is compiled alongside.
 */
package ecg_out_pkg;

   typedef enum logic [1:0]
   {
      MASK_IDLE   = 2'b01,
      MASK_ACTIVE = 2'b10
   } mask_state_e;

   typedef struct packed {
      logic [2:0]       bypass;
      logic [5:0]       ready_src;
      logic             sync_drive;
      logic [5:0]       sync_src;
      logic [1:0]       mask_ctl;
      logic [7:0]       alarm_mask;
      logic [3:0]       misc_cnt;
      logic [3:0]       det_cnt;
      logic [6:0]       loop_cfg;
      logic [12:0]      flt_meta;
      logic [12:0]      flt_sync;
      logic [12:0][4:0] flt_run;
      logic [15:0]      tick_div;
      mask_state_e      mstate;
      logic [3:0]       mask_left;
      logic             go_prev;
      logic [5:0]       rdy_flags;
      logic [3:0]       loop_ptr;
      logic [7:0]       rdata;
      logic             ready_n;
      logic             sync_n;
      logic             fault_n;
   } state_s;

endpackage

// ===== rtl/ecg_frontend_output_control.sv
/*
 * Output and alarm control for a three-channel biopotential front end:
 * filter bypass, ready and sync pin sourcing, ready masking, alarm
 * masking with debounce, and loop read-back of the data registers.
 * Assumes conversion data, ready pulses and control levels come from
 * logic on i_sys_clk; fault conditions arrive asynchronously.
 */
`timescale 1ns/1ps

`include "ecg_out_map.svh"

module ecg_frontend_output_control
#(
   parameter int SAMPLE_DIV = `SAMPLE_DIV_DEFAULT
)
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   input  wire logic [2:0]  i_ecg_drdy,
   input  wire logic [2:0]  i_pace_drdy,
   input  wire logic [2:0]  i_ecg_enabled,
   input  wire logic        i_pace_double,
   input  wire logic        i_conversion_go,
   input  wire logic        i_sync_lost,
   input  wire logic [15:0] i_pace_data_ch1,
   input  wire logic [15:0] i_pace_data_ch2,
   input  wire logic [15:0] i_pace_data_ch3,
   input  wire logic [23:0] i_ecg_data_ch1,
   input  wire logic [23:0] i_ecg_data_ch2,
   input  wire logic [23:0] i_ecg_data_ch3,
   input  wire logic        i_sync_edge_fault,
   input  wire logic [2:0]  i_chan_fault,
   input  wire logic [5:0]  i_detach_signals,
   input  wire logic        i_supply_low,
   input  wire logic        i_leg_drive_rail,
   input  wire logic        i_common_mode_fault,
   output logic      [2:0]  o_bypass_filter,
   output logic             o_sample_ready_n,
   output logic             o_sync_out_n,
   output logic             o_sync_oe,
   output logic             o_fault_pin_n
);
   import ecg_out_pkg::*;

   state_s           cur;
   state_s           next_cur;
   logic [12:0]      raw_fault;
   logic [12:0]      hide;
   logic [12:0]      pass;
   logic [12:0][4:0] next_run;
   logic             tick;
   logic [15:0]      byte_en;
   logic [7:0]       data_byte [16];
   logic [5:0]       src_pulse;
   logic             period_ev;

   // First enabled byte index at or after a start point, with wrap
   function automatic logic [3:0] find_enabled(input logic [15:0] en,
                                               input logic [3:0]  from);
      logic [3:0] idx;
      logic [3:0] hit;
      logic       found;
      hit   = from;
      found = 1'b0;
      for (int k = 0; k < 16; k++)
      begin
         idx = from + 4'(k);
         if (!found && en[idx])
         begin
            hit   = idx;
            found = 1'b1;
         end
      end
      return hit;
   endfunction

   // Fault order: detach 0..5, common-mode, rail, supply, ch1..3, sync
   assign raw_fault = {i_sync_edge_fault, i_chan_fault, i_supply_low,
                       i_leg_drive_rail, i_common_mode_fault,
                       i_detach_signals};
   assign hide[12:9] = cur.alarm_mask[7:4];
   assign hide[8:6]  = cur.alarm_mask[2:0];
   assign hide[5:0]  = {6{cur.alarm_mask[`DETACH_MASK_BIT]}};

   // Alarm sample strobe from the divider
   // Sampling slower than the clock keeps short glitches from counting
   assign tick = (cur.tick_div == 16'(SAMPLE_DIV - 1));

   // Ready sources: bits 0..2 pace, 3..5 ECG
   assign src_pulse = {i_ecg_drdy, i_pace_drdy};

   // Masking period event from first enabled ECG channel, else pace 1
   // Pace channel 1 stands in for the period when no ECG channel runs
   always_comb
   begin
      if (i_ecg_enabled[0])
         period_ev = i_ecg_drdy[0];
      else if (i_ecg_enabled[1])
         period_ev = i_ecg_drdy[1];
      else if (i_ecg_enabled[2])
         period_ev = i_ecg_drdy[2];
      else
         period_ev = i_pace_drdy[0];
   end

   // Per-condition consecutive sample filters
   genvar g;
   generate
      for (g = 0; g < 13; g++)
      begin : g_filter
         logic [4:0] need;
         assign need = (g < 6) ? {1'b0, cur.det_cnt} + 5'd1
                               : {1'b0, cur.misc_cnt} + 5'd1;
         assign pass[g] = (cur.flt_run[g] >= need);
         always_comb
         begin
            if (!tick)
               next_run[g] = cur.flt_run[g];
            else if (!cur.flt_sync[g])
               next_run[g] = 5'd0;
            else if (cur.flt_run[g] >= need)
               next_run[g] = cur.flt_run[g];
            else
               next_run[g] = cur.flt_run[g] + 5'd1;
         end
      end
   endgenerate

   // Loop byte enables per data register
   // Status byte
   assign byte_en[0]     = cur.loop_cfg[0];
   assign byte_en[2:1]   = {2{cur.loop_cfg[1]}};
   assign byte_en[4:3]   = {2{cur.loop_cfg[2]}};
   assign byte_en[6:5]   = {2{cur.loop_cfg[3]}};
   assign byte_en[9:7]   = {3{cur.loop_cfg[4]}};
   assign byte_en[12:10] = {3{cur.loop_cfg[5]}};
   assign byte_en[15:13] = {3{cur.loop_cfg[6]}};

   // Data register image, upper byte first
   assign data_byte[0]  = {cur.rdy_flags, ~cur.fault_n, 1'b0};
   assign data_byte[1]  = i_pace_data_ch1[15:8];
   assign data_byte[2]  = i_pace_data_ch1[7:0];
   assign data_byte[3]  = i_pace_data_ch2[15:8];
   assign data_byte[4]  = i_pace_data_ch2[7:0];
   assign data_byte[5]  = i_pace_data_ch3[15:8];
   assign data_byte[6]  = i_pace_data_ch3[7:0];
   assign data_byte[7]  = i_ecg_data_ch1[23:16];
   assign data_byte[8]  = i_ecg_data_ch1[15:8];
   assign data_byte[9]  = i_ecg_data_ch1[7:0];
   assign data_byte[10] = i_ecg_data_ch2[23:16];
   assign data_byte[11] = i_ecg_data_ch2[15:8];
   assign data_byte[12] = i_ecg_data_ch2[7:0];
   assign data_byte[13] = i_ecg_data_ch3[23:16];
   assign data_byte[14] = i_ecg_data_ch3[15:8];
   assign data_byte[15] = i_ecg_data_ch3[7:0];

   // Next-state logic for the whole block
   always_comb
   begin
      logic       data_rd;
      logic       loop_rd;
      logic       status_rd;
      logic       mask_trig;
      logic [3:0] lidx;
      data_rd   = 1'b0;
      loop_rd   = 1'b0;
      status_rd = 1'b0;
      mask_trig = 1'b0;
      lidx      = find_enabled(byte_en, cur.loop_ptr);
      next_cur  = cur;

      // Register writes; reserved bits dropped
      // Reserved bits ignored
      if (i_wr)
      begin
         case (i_addr)
            `OFS_FILTER_BYPASS:  next_cur.bypass     = i_wdata[2:0];
            `OFS_READY_SRC:      next_cur.ready_src  = i_wdata[5:0];
            `OFS_SYNC_CTRL:
            begin
               next_cur.sync_drive = ~i_wdata[`SYNC_OFF_BIT];
               next_cur.sync_src = i_wdata[5:0];
            end
            `OFS_READY_MASKING:  next_cur.mask_ctl   = i_wdata[1:0];
            `OFS_ALARM_MASK:     next_cur.alarm_mask = i_wdata;
            `OFS_ALARM_DEBOUNCE:
            begin
               next_cur.misc_cnt = i_wdata[7:4];
               next_cur.det_cnt  = i_wdata[3:0];
            end
            `OFS_LOOP_CFG:
            begin
               next_cur.loop_cfg = i_wdata[6:0];
               next_cur.loop_ptr = 4'd0;
            end
            default: ;
         endcase
      end

      // Register reads, data valid the next cycle only
      next_cur.rdata = 8'h00;
      if (i_rd)
      begin
         case (i_addr)
            `OFS_FILTER_BYPASS:  next_cur.rdata = {5'h00, cur.bypass};
            `OFS_READY_SRC:      next_cur.rdata = {2'h0, cur.ready_src};
            `OFS_SYNC_CTRL:
               next_cur.rdata = {1'b0, ~cur.sync_drive, cur.sync_src};
            `OFS_READY_MASKING:  next_cur.rdata = {6'h00, cur.mask_ctl};
            `OFS_ALARM_MASK:     next_cur.rdata = cur.alarm_mask;
            `OFS_ALARM_DEBOUNCE:
               next_cur.rdata = {cur.misc_cnt, cur.det_cnt};
            `OFS_LOOP_CFG:       next_cur.rdata = {1'b0, cur.loop_cfg};
            // Pointer is kept between reads so the walk resumes in place
            // Loop port walk
            `OFS_LOOP_PORT:
            begin
               if (|byte_en)
               begin
                  next_cur.rdata    = data_byte[lidx];
                  next_cur.loop_ptr = lidx + 4'd1;
                  loop_rd           = 1'b1;
                  status_rd         = (lidx == 4'd0);
               end
            end
            default:
            begin
               if (i_addr >= `OFS_DATA_FIRST && i_addr <= `OFS_DATA_LAST)
               begin
                  next_cur.rdata = data_byte[i_addr[3:0]];
                  data_rd        = 1'b1;
                  status_rd      = (i_addr == `OFS_DATA_FIRST);
               end
            end
         endcase
      end

      // Ready flags: status read clears, new ready wins
      // A pulse landing with the status read is kept, never dropped
      if (status_rd)
         next_cur.rdy_flags = 6'h00;
      next_cur.rdy_flags = next_cur.rdy_flags | src_pulse;

      // Masking triggers
      next_cur.go_prev = i_conversion_go;
      if (i_conversion_go && !cur.go_prev
          && !cur.mask_ctl[`STARTUP_MASK_BIT])
         mask_trig = 1'b1;
      if (i_sync_lost && !cur.mask_ctl[`RESYNC_MASK_BIT])
         mask_trig = 1'b1;

      // Masking interval state machine
      // A new trigger restarts the count, so repeated losses extend it
      case (cur.mstate)
         MASK_IDLE: ;
         MASK_ACTIVE:
         begin
            if (period_ev)
            begin
               next_cur.mask_left = cur.mask_left - 4'd1;
               if (cur.mask_left == 4'd1)
                  next_cur.mstate = MASK_IDLE;
            end
         end
         default: next_cur.mstate = MASK_IDLE;
      endcase
      if (mask_trig)
      begin
         next_cur.mstate = MASK_ACTIVE;
         if (|i_ecg_enabled)
            next_cur.mask_left = `MASK_PERIODS_ECG;
         else if (i_pace_double)
            next_cur.mask_left = `MASK_PERIODS_PACE2;
         else
            next_cur.mask_left = `MASK_PERIODS_PACE1;
      end

      // Ready pin: data read releases, selected ready asserts
      // Selected ready source
      if (data_rd || loop_rd)
         next_cur.ready_n = 1'b1;
      if (|(cur.ready_src & src_pulse) && cur.mstate == MASK_IDLE)
         next_cur.ready_n = 1'b0;

      next_cur.sync_n = ~|(cur.sync_src & src_pulse);

      // Fault synchronisers, sampler and filter counts
      // Only the second stage is read; the first may still be settling
      next_cur.flt_meta = raw_fault;
      next_cur.flt_sync = cur.flt_meta;
      next_cur.tick_div = tick ? 16'h0000 : cur.tick_div + 16'h0001;
      next_cur.flt_run  = next_run;
      next_cur.fault_n  = ~|(pass & ~hide);

      if (i_rst)
      begin
         next_cur            = '0;
         next_cur.bypass     = `RST_FILTER_BYPASS;
         next_cur.ready_src  = `RST_READY_SRC;
         next_cur.sync_drive = ~`RST_SYNC_OFF;
         next_cur.sync_src   = `RST_SYNC_SRC;
         next_cur.mask_ctl   = `RST_READY_MASKING;
         next_cur.alarm_mask = `RST_ALARM_MASK;
         next_cur.misc_cnt   = `RST_DEBOUNCE;
         next_cur.det_cnt    = `RST_DEBOUNCE;
         next_cur.loop_cfg   = `RST_LOOP_CFG;
         next_cur.mstate     = MASK_IDLE;
         next_cur.ready_n    = 1'b1;
         next_cur.sync_n     = 1'b1;
         next_cur.fault_n    = 1'b1;
      end
   end

   // State register
   // Reset is folded into the next-state logic, so one plain flop bank
   always_ff @(posedge i_sys_clk)
   begin
      cur <= next_cur;
   end

   // Outputs straight from the state register
   // Bypass per channel
   assign o_bypass_filter  = cur.bypass;
   assign o_rdata          = cur.rdata;
   assign o_sample_ready_n = cur.ready_n;
   assign o_sync_out_n     = cur.sync_n;
   // Held as a drive enable so the pin needs no gate after the flop
   // Sync driver enable
   assign o_sync_oe        = cur.sync_drive;
   assign o_fault_pin_n    = cur.fault_n;

endmodule // ecg_frontend_output_control

// ===== sim/ecg_out_assertions.sv
/*
 * Port checker for the front-end output control block.
 * Assumes it is bound to the block from the testbench top.
 */
`timescale 1ns/1ps

module ecg_out_checker
#(
   parameter int SAMPLE_DIV = 16
)
(
   input wire logic       i_sys_clk,
   input wire logic       i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [2:0] i_ecg_drdy,
   input wire logic [2:0] i_pace_drdy,
   input wire logic       i_conversion_go,
   input wire logic [7:0] o_rdata,
   input wire logic [2:0] o_bypass_filter,
   input wire logic       o_sample_ready_n,
   input wire logic       o_sync_out_n,
   input wire logic       o_sync_oe
);
   logic any_drdy;
   logic startup_off;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   // Any ready pulse from any source
   assign any_drdy = |{i_ecg_drdy, i_pace_drdy};

   // Shadow of the startup mask disable bit
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         startup_off <= 1'b0;
      else if (i_wr && i_addr == 8'h29)
         startup_off <= i_wdata[1];
   end

   a_bypass_write:
      assert property (i_wr && i_addr == 8'h26
         |=> o_bypass_filter == $past(i_wdata[2:0]))
      else $error("Bypass output not written");
   a_sync_dir:
      assert property (i_wr && i_addr == 8'h28
         |=> o_sync_oe == !$past(i_wdata[6]))
      else $error("Sync driver enable wrong");
   a_ready_cause:
      assert property (o_sample_ready_n && !any_drdy |=> o_sample_ready_n)
      else $error("Ready pin fell without a pulse");
   a_sync_cause:
      assert property (!any_drdy |=> o_sync_out_n)
      else $error("Sync pin fell without a pulse");
   a_ready_release:
      assert property (i_rd && i_addr == 8'h30 && !any_drdy
         |=> o_sample_ready_n)
      else $error("Ready pin not released by status read");
   a_startup_mask:
      assert property ($rose(i_conversion_go) && !startup_off && !i_wr
         && !any_drdy && o_sample_ready_n |=> o_sample_ready_n [*3])
      else $error("Ready pin not masked after start");
   a_rdata_quiet:
      assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("Read data not zero outside a read");
   a_unmapped_zero:
      assert property (i_rd && i_addr == 8'h20 |=> o_rdata == 8'h00)
      else $error("Unmapped read not zero");
endmodule // ecg_out_checker

// ===== sim/ecg_host_model.sv
/*
 * Host model driving the register port of the output control block.
 * Assumes one clock shared with the block; read data one cycle later.
 */
`timescale 1ns/1ps

module ecg_host_model
(
   input  wire logic       i_sys_clk,
   input  wire logic [7:0] i_rdata,
   output logic      [7:0] o_addr,
   output logic      [7:0] o_wdata,
   output logic            o_wr,
   output logic            o_rd
);
   // Idle bus from time zero
   initial
   begin
      o_addr = 8'h00;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_sys_clk);
      o_wr <= 1'b0;
   endtask

   // One-cycle read strobe, data taken in the next cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_sys_clk);
      o_rd <= 1'b1;
      o_addr <= a;
      @(posedge i_sys_clk);
      o_rd <= 1'b0;
      @(posedge i_sys_clk);
      d = i_rdata;
   endtask

   task automatic sync_master(input logic [5:0] s);
      wr(8'h28, {2'b00, s});
   endtask

   task automatic cfg_slave();
      wr(8'h28, 8'h40);
   endtask
endmodule // ecg_host_model

// ===== sim/tb_ecg_frontend_output_control.sv
/*
 * Testbench for the output control block: registers, pin sourcing,
 * ready masking, alarm debounce and loop read-back.
 * Assumes the host model and the checker are compiled alongside.
 */
`timescale 1ns/1ps

module tb_ecg_frontend_output_control;
   logic i_sys_clk, i_rst, go, lost, pdbl, wr, rd;
   logic ready_n, sync_n, sync_oe, fault_n;
   logic [5:0] drdy;
   logic [2:0] ecg_en, bypass;
   logic [7:0] flt, addr, wdata, rdata, rv;
   logic [15:0] p1, p2, p3;
   logic [23:0] e1, e2, e3;
   int errors, n_compared, cycles;

   ecg_host_model host (.i_sys_clk(i_sys_clk), .i_rdata(rdata),
      .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));

   ecg_frontend_output_control #(.SAMPLE_DIV(2)) DUT (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_ecg_drdy(drdy[5:3]), .i_pace_drdy(drdy[2:0]),
      .i_ecg_enabled(ecg_en), .i_pace_double(pdbl),
      .i_conversion_go(go), .i_sync_lost(lost),
      .i_pace_data_ch1(p1), .i_pace_data_ch2(p2), .i_pace_data_ch3(p3),
      .i_ecg_data_ch1(e1), .i_ecg_data_ch2(e2), .i_ecg_data_ch3(e3),
      .i_sync_edge_fault(flt[7]), .i_chan_fault(flt[6:4]),
      .i_detach_signals({6{flt[3]}}), .i_supply_low(flt[2]),
      .i_leg_drive_rail(flt[1]), .i_common_mode_fault(flt[0]),
      .o_bypass_filter(bypass), .o_sample_ready_n(ready_n),
      .o_sync_out_n(sync_n), .o_sync_oe(sync_oe),
      .o_fault_pin_n(fault_n));

   // Clock of 40 ns period
   initial
   begin
      i_sys_clk = 1'b0;
      forever #20 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input string w, input logic [7:0] s,
                      input logic [7:0] e);
      n_compared++;
      if (s !== e)
      begin
         errors++;
         $display("Error %s expected %h seen %h", w, e, s);
      end
   endtask

   task automatic end_sim();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // One-cycle ready pulse on the given sources
   task automatic pulse(input logic [5:0] s);
      @(posedge i_sys_clk);
      drdy <= s;
      @(posedge i_sys_clk);
      drdy <= 6'h00;
      #1;
   endtask

   task automatic t_regs();
      logic [7:0] a [8] = '{8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2e,
                            8'h2f, 8'h20};
      logic [7:0] e [8] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h33,
                            8'h00, 8'h00};
      logic [7:0] m [8] = '{8'h07, 8'h3f, 8'h7f, 8'h03, 8'hff, 8'hff,
                            8'h7f, 8'h00};
      chk("pins", {4'h0, ready_n, sync_n, sync_oe, fault_n}, 8'h0d);
      for (int i = 0; i < 8; i++)
      begin
         host.rd(a[i], rv);
         chk("reset value", rv, e[i]);
         host.wr(a[i], 8'hff);
         host.rd(a[i], rv);
         chk("reserved bits", rv, m[i]);
      end
      chk("bypass", {5'h00, bypass}, 8'h07);
      chk("sync oe", {7'h00, sync_oe}, 8'h00);
      for (int i = 0; i < 8; i++)
         host.wr(a[i], e[i]);
      #1 chk("bypass", {5'h00, bypass}, 8'h00);
      $display("t_regs done");
   endtask

   task automatic t_select();
      for (int k = 0; k < 6; k++)
      begin
         host.wr(8'h27, 8'h01 << k);
         host.sync_master(6'h01 << k);
         #1 chk("sync oe", {7'h00, sync_oe}, 8'h01);
         pulse(6'h01 << k);
         chk("ready low", {7'h00, ready_n}, 8'h00);
         chk("sync low", {7'h00, sync_n}, 8'h00);
         @(posedge i_sys_clk);
         #1 chk("sync one cycle", {7'h00, sync_n}, 8'h01);
         host.rd(8'h30, rv);
         #1 chk("ready release", {7'h00, ready_n}, 8'h01);
         pulse(6'h01 << ((k + 1) % 6));
         chk("other src", {6'h00, ready_n, sync_n}, 8'h03);
      end
      host.cfg_slave();
      host.wr(8'h27, 8'h00);
      pulse(6'h3f);
      chk("slave", {6'h00, ready_n, sync_n}, 8'h03);
      chk("slave oe", {7'h00, sync_oe}, 8'h00);
      $display("t_select done");
   endtask

   // Trigger a mask, count ignored pulses, then expect the pin
   task automatic t_mask(input bit lose, input logic [7:0] ctl,
                         input logic [2:0] en, input logic dbl,
                         input logic [5:0] s, input int ign,
                         input int extra);
      host.wr(8'h29, ctl);
      host.wr(8'h27, {2'b00, s});
      ecg_en <= en;
      pdbl <= dbl;
      @(posedge i_sys_clk);
      if (lose)
         lost <= 1'b1;
      else
         go <= 1'b1;
      @(posedge i_sys_clk);
      lost <= 1'b0;
      go <= 1'b0;
      repeat (ign)
      begin
         pulse(s);
         chk("masked", {7'h00, ready_n}, 8'h01);
      end
      repeat (extra) pulse(s);
      chk("after mask", {7'h00, ready_n}, 8'h00);
      host.rd(8'h30, rv);
      $display("t_mask done");
   endtask

   task automatic t_alarm();
      for (int b = 0; b < 8; b++)
      begin
         host.wr(8'h2a, 8'h00);
         flt <= 8'h01 << b;
         repeat (9) @(posedge i_sys_clk);
         #1 chk("debounce", {7'h00, fault_n}, 8'h01);
         repeat (20) @(posedge i_sys_clk);
         #1 chk("alarm", {7'h00, fault_n}, 8'h00);
         host.rd(8'h30, rv);
         chk("alarm status", {7'h00, rv[1]}, 8'h01);
         flt <= 8'h00;
         repeat (10) @(posedge i_sys_clk);
         #1 chk("alarm off", {7'h00, fault_n}, 8'h01);
         host.wr(8'h2a, 8'h01 << b);
         flt <= 8'h01 << b;
         repeat (26) @(posedge i_sys_clk);
         #1 chk("masked", {7'h00, fault_n}, 8'h01);
         @(posedge i_sys_clk);
         flt <= 8'h00;
         repeat (10) @(posedge i_sys_clk);
      end
      for (int f = 0; f < 2; f++)
      begin
         host.wr(8'h2e, f ? 8'h0f : 8'hf0);
         flt <= f ? 8'h01 : 8'h08;
         repeat (3) @(posedge i_sys_clk);
         #1 chk("short wait", {7'h00, fault_n}, 8'h01);
         repeat (2) @(posedge i_sys_clk);
         #1 chk("short alarm", {7'h00, fault_n}, 8'h00);
         @(posedge i_sys_clk);
         flt <= 8'h00;
         repeat (10) @(posedge i_sys_clk);
      end
      host.wr(8'h2e, 8'h33);
      $display("t_alarm done");
   endtask

   task automatic t_loop();
      logic [7:0] s1 [5] = '{8'h00, 8'h11, 8'h12, 8'h13, 8'h00};
      logic [7:0] s2 [8] = '{8'h12, 8'h34, 8'h9a, 8'hbc, 8'h31, 8'h32,
                             8'h33, 8'h12};
      p1 <= 16'h1234;
      p3 <= 16'h9abc;
      e1 <= 24'h111213;
      e3 <= 24'h313233;
      host.rd(8'h30, rv);
      host.wr(8'h2f, 8'h11);
      foreach (s1[i])
      begin
         host.rd(8'h50, rv);
         chk("loop", rv, s1[i]);
      end
      host.wr(8'h2f, 8'h4a);
      foreach (s2[i])
      begin
         host.rd(8'h50, rv);
         chk("loop", rv, s2[i]);
      end
      host.wr(8'h2f, 8'h00);
      host.rd(8'h50, rv);
      chk("loop none", rv, 8'h00);
      host.rd(8'h37, rv);
      chk("direct", rv, 8'h11);
      $display("t_loop done");
   endtask

   // Cut a hang short
   always @(posedge i_sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         end_sim();
      end
   end

   // Main sequence
   initial
   begin
      i_rst = 1'b1;
      {go, lost, pdbl, drdy, ecg_en, flt} = '0;
      {p1, p2, p3, e1, e2, e3} = '0;
      repeat (3) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      t_regs();
      t_select();
      t_mask(0, 8'h00, 3'b010, 0, 6'h10, 6, 1);
      t_mask(1, 8'h00, 3'b000, 0, 6'h01, 6, 1);
      t_mask(1, 8'h00, 3'b000, 1, 6'h01, 11, 1);
      t_mask(0, 8'h02, 3'b001, 0, 6'h08, 0, 1);
      t_mask(1, 8'h01, 3'b001, 0, 6'h08, 0, 1);
      t_alarm();
      t_loop();
      end_sim();
   end
endmodule // tb_ecg_frontend_output_control

bind ecg_frontend_output_control ecg_out_checker
   #(.SAMPLE_DIV(SAMPLE_DIV)) u_check (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .i_ecg_drdy(i_ecg_drdy), .i_pace_drdy(i_pace_drdy),
   .i_conversion_go(i_conversion_go), .o_rdata(o_rdata),
   .o_bypass_filter(o_bypass_filter),
   .o_sample_ready_n(o_sample_ready_n),
   .o_sync_out_n(o_sync_out_n), .o_sync_oe(o_sync_oe));
